// ==== design/tadc_serial_if.sv ====
// Function
// - each result bit is shifted out on a falling serial clock edge.
// - serial data out is not driven while select is high.
// - busy is a logic output released while select is high.
// - control bits on serial input are sampled on rising serial clock edges.
// - select low enables the shift register and allows conversions to start.
// - conversion steps are timed from the host serial clock only.
// - acquisition starts on the fifth falling edge after the start bit.
// - acquisition lasts exactly three serial clock cycles.
// - pen touch interrupt is open drain, pulled high outside.
// - results are straight unsigned binary.
// - result goes out msb first, then 11 bits, then zeros.
`include "tadc_map.svh"
`default_nettype none
module tadc_serial_if
#(
    parameter int RES_BITS  = `TADC_RES_BITS,
    parameter int CTRL_BITS = `TADC_CTRL_BITS
)
(
    input  wire logic                 clk_sys,
    input  wire logic                 arst_n,
    input  wire logic                 cs_n,
    input  wire logic                 host_serial_clock,
    input  wire logic                 din,
    input  wire logic                 pen_touched,
    input  wire logic                 cmp_above,
    output logic                      dout_o,
    output logic                      dout_oe,
    output logic                      busy_o,
    output logic                      busy_oe,
    output logic                      pen_touch_irq_n_o,
    output logic                      pen_touch_irq_n_oe,
    output logic                      track_o,
    output logic [RES_BITS-1:0]       dac_code_o,
    output logic [CTRL_BITS-1:0]      ctrl_word_o,
    output logic                      ctrl_valid_o,
    output logic [RES_BITS-1:0]       result_o
);
    tadc_sync_if sy ();

    tadc_pin_sync u_sync
    (
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .cs_n_pin (cs_n),
        .sclk_pin (host_serial_clock),
        .din_pin  (din),
        .pen_pin  (pen_touched),
        .sy       (sy)
    );

    // ----------------------------------------
    // sequencing state
    // ----------------------------------------
    tadc_pkg::tadc_state_t state_r;
    tadc_pkg::tadc_state_t state_nxt;
    logic [4:0]            fall_cnt_r;
    logic [CTRL_BITS-1:0]  ctrl_r;
    logic [RES_BITS-1:0]   sar_r;
    logic [3:0]            bit_idx_r;
    logic                  cmp_s1_r;
    logic                  cmp_s2_r;
    logic                  cmp_s3_r;
    logic                  cmp_st_r;
    logic                  fall;
    logic                  rise;
    logic                  active;

    assign active = ~sy.cs_n;
    assign fall   = active & sy.sclk_fall;
    assign rise   = active & sy.sclk_rise;

    // comparator is analog, so it arrives async
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cmp_s1_r <= 1'b0;
            cmp_s2_r <= 1'b0;
            cmp_s3_r <= 1'b0;
            cmp_st_r <= 1'b0;
        end
        else
        begin
            cmp_s1_r <= cmp_above;
            cmp_s2_r <= cmp_s1_r;
            cmp_s3_r <= cmp_s2_r;
            if (cmp_s2_r == cmp_s3_r)
                cmp_st_r <= cmp_s3_r;
        end
    end

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            tadc_pkg::TADC_IDLE:
                if (rise && sy.din)
                    state_nxt = tadc_pkg::TADC_CMD;
            tadc_pkg::TADC_CMD:
                if (fall && fall_cnt_r == 5'(`TADC_ACQ_START + `TADC_ACQ_CYCLES - 1))
                    state_nxt = tadc_pkg::TADC_CONV;
            tadc_pkg::TADC_CONV:
                if (fall && bit_idx_r == 4'h0)
                    state_nxt = tadc_pkg::TADC_DONE;
            tadc_pkg::TADC_DONE:
                state_nxt = tadc_pkg::TADC_DONE;
            default:
                state_nxt = tadc_pkg::TADC_IDLE;
        endcase
        if (!active)
            state_nxt = tadc_pkg::TADC_IDLE;
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            state_r <= tadc_pkg::TADC_IDLE;
        else
            state_r <= state_nxt;
    end

    // falling edges counted from the start bit
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            fall_cnt_r <= 5'h00;
        else if (state_r == tadc_pkg::TADC_IDLE)
            fall_cnt_r <= 5'h00;
        else if (fall && fall_cnt_r != 5'h1f)
            fall_cnt_r <= fall_cnt_r + 5'h01;
    end

    // ----------------------------------------
    // control word capture
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl_r       <= '0;
            ctrl_word_o  <= '0;
            ctrl_valid_o <= 1'b0;
        end
        else
        begin
            ctrl_valid_o <= 1'b0;
            if (rise && state_nxt == tadc_pkg::TADC_CMD)
            begin
                ctrl_r <= {ctrl_r[CTRL_BITS-2:0], sy.din};
                if (fall_cnt_r == 5'(CTRL_BITS - 1))
                begin
                    ctrl_word_o  <= {ctrl_r[CTRL_BITS-2:0], sy.din};
                    ctrl_valid_o <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------
    // acquisition and successive approximation
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            track_o <= 1'b0;
        else if (!active || (fall && fall_cnt_r == 5'(`TADC_ACQ_START + `TADC_ACQ_CYCLES - 1)))
            track_o <= 1'b0;
        else if (state_r == tadc_pkg::TADC_CMD && fall && fall_cnt_r == 5'(`TADC_ACQ_START - 1))
            track_o <= 1'b1;
    end

    // one decision per falling edge; trial bit set ahead of it
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sar_r     <= '0;
            bit_idx_r <= 4'h0;
            result_o  <= '0;
        end
        else if (state_r == tadc_pkg::TADC_CMD && state_nxt == tadc_pkg::TADC_CONV)
        begin
            sar_r     <= {1'b1, {(RES_BITS-1){1'b0}}};
            bit_idx_r <= 4'(RES_BITS - 1);
        end
        else if (state_r == tadc_pkg::TADC_CONV && fall)
        begin
            // keep or drop the trial bit, then try the next one
            sar_r[bit_idx_r] <= cmp_st_r;
            if (bit_idx_r != 4'h0)
                sar_r[bit_idx_r - 4'h1] <= 1'b1;
            bit_idx_r <= bit_idx_r - 4'h1;
            if (bit_idx_r == 4'h0)
                result_o <= {sar_r[RES_BITS-1:1], cmp_st_r};
        end
    end

    assign dac_code_o = sar_r;

    // ----------------------------------------
    // pin drivers
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dout_o  <= 1'b0;
            dout_oe <= 1'b0;
            busy_o  <= 1'b0;
            busy_oe <= 1'b0;
        end
        else
        begin
            dout_oe <= active;
            busy_oe <= active;
            busy_o  <= (state_nxt == tadc_pkg::TADC_CONV);
            if (!active)
                dout_o <= 1'b0;
            else if (state_r == tadc_pkg::TADC_CONV && fall)
                dout_o <= cmp_st_r;
            else if (state_r == tadc_pkg::TADC_DONE && fall)
                dout_o <= 1'b0;
        end
    end

    // open drain: only ever drives low
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pen_touch_irq_n_o  <= 1'b0;
            pen_touch_irq_n_oe <= 1'b0;
        end
        else
        begin
            pen_touch_irq_n_o  <= 1'b0;
            pen_touch_irq_n_oe <= sy.pen & ~busy_o;
        end
    end
endmodule : tadc_serial_if
`default_nettype wire

// ==== design/tadc_map.svh ====
`ifndef TADC_MAP_SVH
`define TADC_MAP_SVH
// ----------------------------------------
// widths and counts
// ----------------------------------------
`define TADC_RES_BITS     12
`define TADC_CTRL_BITS    8
`define TADC_ACQ_START    5
`define TADC_ACQ_CYCLES   3
`define TADC_SYNC_STAGES  3
`define TADC_PEN_SYNC     3
`endif

// ==== design/tadc_pkg.sv ====
`default_nettype none
package tadc_pkg;
    typedef enum logic [1:0]
    {
        TADC_IDLE = 2'b00,
        TADC_CMD  = 2'b01,
        TADC_CONV = 2'b10,
        TADC_DONE = 2'b11
    } tadc_state_t;
endpackage : tadc_pkg
`default_nettype wire

// ==== design/tadc_sync_if.sv ====
`default_nettype none
interface tadc_sync_if;
    logic cs_n;
    logic sclk;
    logic din;
    logic pen;
    logic sclk_rise;
    logic sclk_fall;
    modport src (input cs_n, input sclk, input din, input pen, input sclk_rise, input sclk_fall);
    modport drv (output cs_n, output sclk, output din, output pen, output sclk_rise, output sclk_fall);
endinterface : tadc_sync_if
`default_nettype wire

// ==== design/tadc_pin_sync.sv ====
`include "tadc_map.svh"
`default_nettype none
module tadc_pin_sync
(
    input  wire logic clk_sys,
    input  wire logic arst_n,
    input  wire logic cs_n_pin,
    input  wire logic sclk_pin,
    input  wire logic din_pin,
    input  wire logic pen_pin,
    tadc_sync_if.drv  sy
);
    // ----------------------------------------
    // three stages; a change counts when stages 2 and 3 agree
    // ----------------------------------------
    logic [3:0] s1_r;
    logic [3:0] s2_r;
    logic [3:0] s3_r;
    logic [3:0] st_r;
    logic       sclk_prev_r;

    // reset to the idle pin levels (select high, the rest low) so that no
    // false edge or touch follows reset
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s1_r <= 4'h1;
            s2_r <= 4'h1;
            s3_r <= 4'h1;
            st_r <= 4'h1;
        end
        else
        begin
            s1_r <= {pen_pin, din_pin, sclk_pin, cs_n_pin};
            s2_r <= s1_r;
            s3_r <= s2_r;
            // take stage 3 where stages 2 and 3 agree, hold otherwise
            st_r <= (st_r & (s2_r ^ s3_r)) | (s3_r & ~(s2_r ^ s3_r));
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            sclk_prev_r <= 1'b0;
        else
            sclk_prev_r <= st_r[1];
    end

    assign sy.cs_n      = st_r[0];
    assign sy.sclk      = st_r[1];
    assign sy.din       = st_r[2];
    assign sy.pen       = st_r[3];
    assign sy.sclk_rise = st_r[1] & ~sclk_prev_r;
    assign sy.sclk_fall = ~st_r[1] & sclk_prev_r;
endmodule : tadc_pin_sync
`default_nettype wire

// ==== dv/tadc_serial_if_assertions.sv ====
`default_nettype none
module tadc_serial_if_assertions
#(
    parameter int RES_BITS  = 12,
    parameter int CTRL_BITS = 8
)
(
    input wire logic                 clk_sys,
    input wire logic                 arst_n,
    input wire logic                 cs_n,
    input wire logic                 host_serial_clock,
    input wire logic                 pen_touched,
    input wire logic                 dout_o,
    input wire logic                 dout_oe,
    input wire logic                 busy_o,
    input wire logic                 busy_oe,
    input wire logic                 pen_touch_irq_n_o,
    input wire logic                 pen_touch_irq_n_oe,
    input wire logic                 track_o,
    input wire logic [RES_BITS-1:0]  dac_code_o,
    input wire logic [CTRL_BITS-1:0] ctrl_word_o,
    input wire logic                 ctrl_valid_o
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    // ----------------------------------------
    // pin edge ages, saturating; serial clock falls counted while acquiring
    // ----------------------------------------
    logic [3:0] fall_age_r;
    logic [3:0] edge_age_r;
    logic [2:0] trk_falls_r;
    always_ff @(posedge clk_sys or negedge arst_n)
        if (!arst_n)
            fall_age_r <= 4'h0;
        else if ($fell(host_serial_clock))
            fall_age_r <= 4'h0;
        else if (fall_age_r != 4'hf)
            fall_age_r <= fall_age_r + 4'h1;
    // cs edges count too: a deselect may legally move the converter state
    always_ff @(posedge clk_sys or negedge arst_n)
        if (!arst_n)
            edge_age_r <= 4'h0;
        else if ($changed(host_serial_clock) || $changed(cs_n))
            edge_age_r <= 4'h0;
        else if (edge_age_r != 4'hf)
            edge_age_r <= edge_age_r + 4'h1;
    always_ff @(posedge clk_sys or negedge arst_n)
        if (!arst_n)
            trk_falls_r <= 3'h0;
        else if (!track_o)
            trk_falls_r <= 3'h0;
        else if ($fell(host_serial_clock))
            trk_falls_r <= trk_falls_r + 3'h1;
    // ----------------------------------------
    // properties
    // ----------------------------------------
    sequence cs_off_s;
        cs_n [*8];
    endsequence
    sequence cs_on_s;
        !cs_n [*8];
    endsequence
    dout_release_a: assert property (cs_off_s |-> !dout_oe)
        else $error("dout driven while deselected");
    busy_release_a: assert property (cs_off_s |-> !busy_oe)
        else $error("busy driven while deselected");
    port_enable_a: assert property (cs_on_s |-> dout_oe && busy_oe)
        else $error("outputs not enabled while selected");
    dout_fall_a: assert property ($changed(dout_o) && dout_oe && $stable(dout_oe) |-> fall_age_r < 4'ha)
        else $error("dout moved away from a falling edge");
    track_edge_a: assert property ($rose(track_o) |-> fall_age_r < 4'ha)
        else $error("acquire began away from a falling edge");
    track_len_a: assert property ($fell(track_o) && !cs_n |-> trk_falls_r == 3'h3)
        else $error("acquire did not span three clocks");
    busy_follow_a: assert property ($fell(track_o) && !cs_n |-> ##[0:2] busy_o)
        else $error("busy did not follow acquire");
    sar_clocked_a: assert property (edge_age_r > 4'h9 |-> $stable(dac_code_o) && $stable(busy_o))
        else $error("conversion advanced without a serial clock");
    start_bit_a: assert property (ctrl_valid_o |-> ctrl_word_o[CTRL_BITS-1] ##1 !ctrl_valid_o)
        else $error("control byte without start bit");
    pen_drive_a: assert property ((pen_touched && !busy_o) [*8] |-> pen_touch_irq_n_oe && !pen_touch_irq_n_o)
        else $error("pen line not pulled low");
    pen_release_a: assert property (!pen_touched [*8] |-> !pen_touch_irq_n_oe)
        else $error("pen line held without touch");
endmodule : tadc_serial_if_assertions
bind tadc_serial_if tadc_serial_if_assertions #(.RES_BITS(RES_BITS), .CTRL_BITS(CTRL_BITS)) chk (.*);
`default_nettype wire

// ==== dv/tadc_host_model.sv ====
`default_nettype none
module tadc_host_model
(
    input  wire logic clk_sys,
    input  wire logic dout_w,
    input  wire logic busy_w,
    output var logic  cs_n,
    output var logic  host_serial_clock,
    output var logic  din
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HP = 8;
    logic [23:0] rx;
    logic [23:0] bz;
    initial
    begin
        cs_n              = 1'b1;
        host_serial_clock = 1'b0;
        din               = 1'b0;
    end
    // n clocks; sel low leaves select off to show the device ignores them
    task automatic xfer(input logic [7:0] cmd, input int n, input logic sel);
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk_sys);
            cs_n <= ~sel;
            din  <= (i < 8) ? cmd[7-i] : 1'b0;
            repeat (HP) @(posedge clk_sys);
            host_serial_clock <= 1'b1;
            repeat (HP) @(posedge clk_sys);
            rx                <= {rx[22:0], dout_w};
            bz                <= {bz[22:0], busy_w};
            host_serial_clock <= 1'b0;
        end
        // clock stays low until select is dropped
        repeat (HP) @(posedge clk_sys);
        cs_n <= 1'b1;
    endtask : xfer
endmodule : tadc_host_model
`default_nettype wire

// ==== dv/testbench.sv ====
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed
    {
        logic [7:0]  cmd;
        logic [11:0] ain;
    } tadc_row_t;
    localparam tadc_row_t ROWS [5] = '{'{8'h87, 12'h000}, '{8'h97, 12'hfff}, '{8'hd3, 12'h800},
                                      '{8'ha7, 12'h7ff}, '{8'he1, 12'ha5c}};
    logic        clk_sys;
    logic        arst_n;
    logic        pen_touched;
    logic [11:0] ain;
    logic        cs_n, host_serial_clock, din;
    logic        dout_o, dout_oe, busy_o, busy_oe, track_o, ctrl_valid_o;
    logic        pen_touch_irq_n_o, pen_touch_irq_n_oe;
    logic [11:0] dac_code_o, result_o;
    logic [7:0]  ctrl_word_o;
    logic [7:0]  cw_seen;
    logic        dout_last_r = 1'b0;
    logic        busy_last_r = 1'b0;
    logic [11:0] trk_rises = 12'h000;
    logic [11:0] exp_trk = 12'h000;
    int          fail_count = 0;
    int          total_checks = 0;
    // input sits half an step above code ain, so the conversion must yield ain
    wire  logic  cmp_above = (dac_code_o <= ain);
    // released lines show the inverse of their last level; pen line is pulled up
    wire  logic  dout_w = dout_oe ? dout_o : ~dout_last_r;
    wire  logic  busy_w = busy_oe ? busy_o : ~busy_last_r;
    wire  logic  pen_w = pen_touch_irq_n_oe ? pen_touch_irq_n_o : 1'b1;
    tadc_serial_if  uut (.*);
    tadc_host_model host (.*);
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        if (dout_oe === 1'b1)
            dout_last_r <= dout_o;
        if (busy_oe === 1'b1)
            busy_last_r <= busy_o;
        if (ctrl_valid_o === 1'b1)
            cw_seen <= ctrl_word_o;
    end
    always @(posedge track_o)
        trk_rises <= trk_rises + 12'h1;
    // ----------------------------------------
    // checking and closing
    // ----------------------------------------
    task automatic check(input logic [11:0] got, input logic [11:0] exp, input string msg);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : check
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    task automatic frame_checks(input tadc_row_t r);
        repeat (12) @(posedge clk_sys);
        exp_trk = exp_trk + 12'h1;
        check(host.rx[14:3], r.ain, "result bits");
        check({9'h0, host.rx[2:0]}, 12'h000, "trailing zeros");
        check(result_o, r.ain, "result register");
        check({4'h0, cw_seen}, {4'h0, r.cmd}, "control byte");
        check({10'h0, host.bz[15], host.bz[0]}, 12'h002, "busy span");
        check(trk_rises, exp_trk, "acquire count");
        check({11'h0, dout_oe | busy_oe}, 12'h000, "released");
    endtask : frame_checks
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial
    begin
        arst_n      = 1'b0;
        pen_touched = 1'b0;
        ain         = 12'h000;
        repeat (20) @(posedge clk_sys);
        check({11'h0, dout_oe | busy_oe | track_o}, 12'h000, "reset outputs");
        arst_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
        foreach (ROWS[i])
        begin
            ain <= ROWS[i].ain;
            host.xfer(ROWS[i].cmd, 24, 1'b1);
            frame_checks(ROWS[i]);
        end
        $display("done: conversions");
        host.xfer(8'hff, 24, 1'b0);
        check({11'h0, dout_oe | busy_oe}, 12'h000, "deselected drive");
        check(trk_rises, exp_trk, "deselected acquire");
        check({4'h0, cw_seen}, {4'h0, ROWS[4].cmd}, "deselected capture");
        $display("done: deselected clocking");
        ain <= 12'h3c5;
        host.xfer(8'h9b, 14, 1'b1);
        repeat (12) @(posedge clk_sys);
        exp_trk = exp_trk + 12'h1;
        check({11'h0, dout_oe | busy_oe}, 12'h000, "abort release");
        host.xfer(8'h9b, 24, 1'b1);
        frame_checks(tadc_row_t'{8'h9b, 12'h3c5});
        $display("done: abort");
        pen_touched <= 1'b1;
        repeat (12) @(posedge clk_sys);
        check({11'h0, pen_w}, 12'h000, "pen asserted");
        pen_touched <= 1'b0;
        repeat (12) @(posedge clk_sys);
        check({11'h0, pen_w}, 12'h001, "pen released");
        $display("done: pen");
        wrap_up();
    end
    initial
    begin
        repeat (100000) @(posedge clk_sys);
        fail_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
